// ### verilog/fpmc_pkg.sv
// Shared constants and types for the front-panel mode control block.
// Assumes a single 250 MHz system clock and an APB register port.
package fpmc_pkg;

    // Clock rate and debounce time
    localparam int CLK_MHZ         = 250;
    localparam int DEBOUNCE_US     = 10000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

    // Bus and datapath widths
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 8;
    localparam int APB_AW  = 8;
    localparam int APB_DW  = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_PC     = 8'h04;
    localparam logic [7:0] OFS_LEDS   = 8'h08;
    localparam logic [7:0] OFS_CMD    = 8'h0C;

    // Status register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_FLAG_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_RW_BIT   = 4;
    localparam int ST_SW_LSB   = 8;

    // Command register field positions
    localparam int CMD_PRESS_BIT = 0;

    // Reset values
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [7:0]  LEDS_RESET = 8'h00;

    // Bit positions in the packed switch vector
    localparam int SW_DATA_LSB = 0;
    localparam int SW_RW_BIT   = 8;
    localparam int SW_RST_BIT  = 9;
    localparam int SW_LOAD_BIT = 10;
    localparam int SW_BTN_BIT  = 11;
    localparam int SW_COUNT    = 12;

    // Operating mode, coded as {reset switch, load switch}
    typedef enum logic [1:0] {
        MODE_LOAD  = 2'b00,
        MODE_CLEAR = 2'b01,
        MODE_WAIT  = 2'b10,
        MODE_RUN   = 2'b11
    } fpmc_mode_t;

    // Panel memory cycle state
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_BUSY = 2'b01
    } fpmc_xfer_t;

    // Memory request carried to the core's memory
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fpmc_mem_cmd_t;

endpackage

// ### verilog/fpmc_front_panel.sv
// Front-panel mode control: operator switches, mode decode, single-step
// memory load/readback, data and flag LEDs, and an APB register port.
// Assumes the core honours CORE_RESET/CORE_HOLD and that memory answers
// each MEM_REQ with a one-cycle MEM_ACK on the same clock.
`timescale 1ns/10ps

// Function
// - Load mode: one memory cycle per press
// - Clear mode holds reset, clears counter
// - Wait mode freezes core, state kept
// - Run mode lets core execute, resumes
// - Run after reset fetches from zero
// - Write press stores switches, shows, increments
// - Read press shows memory byte, increments
// - Read/write switch up writes, down reads
// - Data LEDs keep last loaded/output byte
// - Flag LED follows core flag always
// - Switch up is one, down zero
module fpmc_front_panel #(
    parameter int unsigned DEBOUNCE_CYC = fpmc_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST_B,
    // Operator panel
    input  wire logic [fpmc_pkg::DATA_W-1:0]   DATA_SWITCHES,
    input  wire logic                          INPUT_PUSHBUTTON,
    input  wire logic                          READ_WRITE_SELECT_SWITCH,
    input  wire logic                          RESET_MODE_SWITCH,
    input  wire logic                          LOAD_MODE_SWITCH,
    output logic      [fpmc_pkg::DATA_W-1:0]   DATA_LEDS,
    output logic                               FLAG_LED,
    // Processor core
    input  wire logic                          CORE_FLAG,
    input  wire logic                          CORE_OUT_STB,
    input  wire logic [fpmc_pkg::DATA_W-1:0]   CORE_OUT_DATA,
    output logic                               CORE_RESET,
    output logic                               CORE_HOLD,
    // Program memory
    output logic                               MEM_REQ,
    output fpmc_pkg::fpmc_mem_cmd_t            MEM_CMD,
    input  wire logic                          MEM_ACK,
    input  wire logic [fpmc_pkg::DATA_W-1:0]   MEM_RDATA,
    // APB slave
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [fpmc_pkg::APB_AW-1:0]   PADDR,
    input  wire logic [fpmc_pkg::APB_DW-1:0]   PWDATA,
    output logic      [fpmc_pkg::APB_DW-1:0]   PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR
);
    import fpmc_pkg::*;

    localparam int CNT_W = $clog2(DEBOUNCE_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                rst_meta_reg;      // Reset release, stage one
    logic                rst_n;             // Synchronised reset, low active
    logic [SW_COUNT-1:0] sw_raw;            // All panel inputs packed
    logic [SW_COUNT-1:0] sw_s1_reg;         // Sync stage one
    logic [SW_COUNT-1:0] sw_s2_reg;         // Sync stage two
    logic [SW_COUNT-1:0] sw_s3_reg;         // Sync stage three
    logic [SW_COUNT-1:0] sw_clean_reg;      // Accepted switch levels
    logic [CNT_W-1:0]    db_cnt_reg;        // Button stable-time counter
    logic                btn_state_reg;     // Debounced button level
    logic                btn_press_reg;     // One pulse per press
    logic                soft_press_reg;    // Press issued over APB
    fpmc_mode_t          mode_reg;          // Decoded operating mode
    fpmc_xfer_t          xfer_reg;          // Panel memory cycle state
    logic [ADDR_W-1:0]   pc_reg;            // Program counter register
    logic                press;             // Any press this cycle
    logic                start;             // Begin a panel memory cycle
    logic                done;              // Panel memory cycle finishes
    logic                apb_setup;         // APB setup phase
    logic                apb_access;        // APB completing edge
    logic                pc_wr;             // Software preset of counter

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Mode from the two switches; up reads as one
    function automatic fpmc_mode_t to_mode(input logic rst_sw,
                                           input logic load_sw);
        to_mode = fpmc_mode_t'({rst_sw, load_sw});
    endfunction

    // Known register offsets
    function automatic logic reg_known(input logic [APB_AW-1:0] a);
        reg_known = (a == OFS_STATUS) || (a == OFS_PC) ||
                    (a == OFS_LEDS)   || (a == OFS_CMD);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    // Two flops so every flop leaves reset on the same edge
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel input synchronisers

    // Switch up drives one, down drives zero; no inversion anywhere
    assign sw_raw = {INPUT_PUSHBUTTON, LOAD_MODE_SWITCH, RESET_MODE_SWITCH,
                     READ_WRITE_SELECT_SWITCH, DATA_SWITCHES};

    genvar gi;
    generate
        for (gi = 0; gi < SW_COUNT; gi = gi + 1) begin : g_sync
            // Three stages; stage one feeds only stage two
            always_ff @(posedge CLK_SYS or negedge rst_n) begin
                if (!rst_n) begin
                    sw_s1_reg[gi]    <= 1'b0;
                    sw_s2_reg[gi]    <= 1'b0;
                    sw_s3_reg[gi]    <= 1'b0;
                    sw_clean_reg[gi] <= 1'b0;
                end else begin
                    sw_s1_reg[gi] <= sw_raw[gi];
                    sw_s2_reg[gi] <= sw_s1_reg[gi];
                    sw_s3_reg[gi] <= sw_s2_reg[gi];
                    // Accept a change only when two stages agree
                    if (sw_s2_reg[gi] == sw_s3_reg[gi]) begin
                        sw_clean_reg[gi] <= sw_s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pushbutton debounce

    // Contact bounce is shorter than the stable time, so one press
    // gives one pulse; very fast double taps merge into one press
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            db_cnt_reg    <= '0;
            btn_state_reg <= 1'b0;
            btn_press_reg <= 1'b0;
        end else begin
            btn_press_reg <= 1'b0;
            if (sw_clean_reg[SW_BTN_BIT] == btn_state_reg) begin
                db_cnt_reg <= '0;                             // Stable
            end else if (db_cnt_reg == CNT_W'(DEBOUNCE_CYC - 1)) begin
                db_cnt_reg    <= '0;
                btn_state_reg <= sw_clean_reg[SW_BTN_BIT];
                btn_press_reg <= sw_clean_reg[SW_BTN_BIT];
            end else begin
                db_cnt_reg <= db_cnt_reg + 1'b1;              // Waiting
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and core control

    // Clear is the safe mode while the panel leaves reset
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_CLEAR;
        end else begin
            mode_reg <= to_mode(sw_clean_reg[SW_RST_BIT],
                                sw_clean_reg[SW_LOAD_BIT]);
        end
    end

    // Reset held in clear; hold in load and wait; free only in run
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            CORE_RESET <= 1'b1;
            CORE_HOLD  <= 1'b1;
        end else begin
            CORE_RESET <= (mode_reg == MODE_CLEAR);
            // Hold keeps every core state, so run resumes in place
            CORE_HOLD  <= (mode_reg == MODE_LOAD) ||
                          (mode_reg == MODE_WAIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel memory cycle

    assign press = btn_press_reg | soft_press_reg;
    // Presses outside load mode or during a cycle are dropped
    assign start = press && (mode_reg == MODE_LOAD) &&
                   (xfer_reg == XFER_IDLE);
    assign done  = (xfer_reg == XFER_BUSY) && MEM_ACK;

    // One request per accepted press, held until acknowledged
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            xfer_reg <= XFER_IDLE;
            MEM_REQ  <= 1'b0;
            MEM_CMD  <= '0;
        end else begin
            case (xfer_reg)
                XFER_IDLE: begin
                    if (start) begin
                        xfer_reg      <= XFER_BUSY;
                        MEM_REQ       <= 1'b1;
                        // Switch up writes, down reads
                        MEM_CMD.we    <= sw_clean_reg[SW_RW_BIT];
                        MEM_CMD.addr  <= pc_reg;
                        MEM_CMD.wdata <= sw_clean_reg[SW_DATA_LSB +: DATA_W];
                    end
                end
                XFER_BUSY: begin
                    if (MEM_ACK) begin
                        xfer_reg <= XFER_IDLE;
                        MEM_REQ  <= 1'b0;
                    end
                end
                default: begin
                    xfer_reg <= XFER_IDLE;
                    MEM_REQ  <= 1'b0;
                end
            endcase
        end
    end

    // Counter: clear wins, then the step, then a software preset
    assign pc_wr = apb_access && PWRITE && (PADDR == OFS_PC) &&
                   (mode_reg != MODE_RUN) && (xfer_reg == XFER_IDLE);

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= PC_RESET;
        end else if (mode_reg == MODE_CLEAR) begin
            pc_reg <= PC_RESET;
        end else if (done) begin
            pc_reg <= pc_reg + 1'b1;
        end else if (pc_wr) begin
            pc_reg <= PWDATA[ADDR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators

    // Last byte written, read back, or sent out by the program
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            DATA_LEDS <= LEDS_RESET;
        end else if (done) begin
            DATA_LEDS <= MEM_CMD.we ? MEM_CMD.wdata : MEM_RDATA;
        end else if (CORE_OUT_STB) begin
            DATA_LEDS <= CORE_OUT_DATA;
        end
    end

    // Same clock as the core, so no synchroniser is needed
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            FLAG_LED <= 1'b0;
        end else begin
            FLAG_LED <= CORE_FLAG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    assign apb_setup  = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE && PREADY;

    // Answer is prepared in setup so every output is a flop;
    // each access therefore takes exactly one wait-free access cycle
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else begin
            PREADY  <= apb_setup;
            PSLVERR <= apb_setup && !reg_known(PADDR);
            PRDATA  <= '0;
            if (apb_setup && !PWRITE) begin
                case (PADDR)
                    OFS_STATUS: begin
                        PRDATA[ST_MODE_LSB +: 2]    <= mode_reg;
                        PRDATA[ST_FLAG_BIT]         <= FLAG_LED;
                        PRDATA[ST_BUSY_BIT]         <= MEM_REQ;
                        PRDATA[ST_RW_BIT]           <= sw_clean_reg[SW_RW_BIT];
                        PRDATA[ST_SW_LSB +: DATA_W] <=
                            sw_clean_reg[SW_DATA_LSB +: DATA_W];
                    end
                    OFS_PC:   PRDATA[ADDR_W-1:0] <= pc_reg;
                    OFS_LEDS: PRDATA[DATA_W-1:0] <= DATA_LEDS;
                    default:  PRDATA <= '0;   // Command and unmapped
                endcase
            end
        end
    end

    // Software press pulse, taken at the completing edge only
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            soft_press_reg <= 1'b0;
        end else begin
            soft_press_reg <= apb_access && PWRITE && (PADDR == OFS_CMD) &&
                              PWDATA[CMD_PRESS_BIT];
        end
    end

endmodule

// ### sim/fpmc_asserts.sv
// Checker for the front-panel block: mode outputs, panel memory cycle,
// LED and flag behaviour. Sees only the top module's ports.
`timescale 1ns/10ps
module fpmc_asserts (
    // Clock and reset
    input wire logic                    CLK_SYS,
    input wire logic                    RST_B,
    // Operator panel
    input wire logic                    RESET_MODE_SWITCH,
    input wire logic                    LOAD_MODE_SWITCH,
    input wire logic [7:0]              DATA_LEDS,
    input wire logic                    FLAG_LED,
    // Core and memory
    input wire logic                    CORE_FLAG,
    input wire logic                    CORE_OUT_STB,
    input wire logic [7:0]              CORE_OUT_DATA,
    input wire logic                    CORE_RESET,
    input wire logic                    CORE_HOLD,
    input wire logic                    MEM_REQ,
    input wire fpmc_pkg::fpmc_mem_cmd_t MEM_CMD,
    input wire logic                    MEM_ACK,
    input wire logic [7:0]              MEM_RDATA
);
    import fpmc_pkg::*;
    ////////////////////////////////////////////////////////////////////
    logic [4:0] age_reg;   // Cycles since reset, saturating
    logic       settled;   // Past internal reset and sync lag
    // Skip early edges: the copied reset still holds the design
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            age_reg <= 5'h00;
        end else if (age_reg != 5'h1F) begin
            age_reg <= age_reg + 5'h01;
        end
    end
    assign settled = (age_reg == 5'h1F);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////
    // Switch pair steady long enough to pass the synchronisers
    sequence s_mode(logic r, logic l);
        (settled && RESET_MODE_SWITCH == r && LOAD_MODE_SWITCH == l) [*8];
    endsequence
    // Memory cycle completes at this edge
    sequence s_ack;
        MEM_REQ && MEM_ACK;
    endsequence
    a_load_holds: assert property (
        s_mode(1'b0, 1'b0) |=> CORE_HOLD && !CORE_RESET)
        else $error("core not held in load mode");
    a_clear_resets: assert property (
        s_mode(1'b0, 1'b1) |=> CORE_RESET)
        else $error("core not reset in clear mode");
    a_wait_freezes: assert property (
        s_mode(1'b1, 1'b0) |=> CORE_HOLD && !CORE_RESET)
        else $error("core not frozen in wait mode");
    a_run_frees: assert property (
        s_mode(1'b1, 1'b1) |=> !CORE_HOLD && !CORE_RESET)
        else $error("core not running in run mode");
    a_req_holds: assert property (
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_CMD))
        else $error("memory request dropped or changed early");
    a_ack_ends_req: assert property (
        s_ack |=> !MEM_REQ)
        else $error("memory request outlives its answer");
    a_write_shows: assert property (
        s_ack ##0 MEM_CMD.we |=> DATA_LEDS == $past(MEM_CMD.wdata))
        else $error("written byte not on data leds");
    a_read_shows: assert property (
        s_ack ##0 !MEM_CMD.we |=> DATA_LEDS == $past(MEM_RDATA))
        else $error("read byte not on data leds");
    a_core_shows: assert property (
        CORE_OUT_STB && !MEM_ACK |=> DATA_LEDS == $past(CORE_OUT_DATA))
        else $error("core output not on data leds");
    a_leds_keep: assert property (
        settled && !MEM_ACK && !CORE_OUT_STB |=> $stable(DATA_LEDS))
        else $error("data leds changed without a cause");
    a_flag_follows: assert property (
        settled |-> FLAG_LED == $past(CORE_FLAG))
        else $error("flag led does not follow core flag");
endmodule
bind fpmc_front_panel fpmc_asserts u_asserts (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .RESET_MODE_SWITCH(RESET_MODE_SWITCH),
    .LOAD_MODE_SWITCH(LOAD_MODE_SWITCH), .DATA_LEDS(DATA_LEDS),
    .FLAG_LED(FLAG_LED), .CORE_FLAG(CORE_FLAG),
    .CORE_OUT_STB(CORE_OUT_STB), .CORE_OUT_DATA(CORE_OUT_DATA),
    .CORE_RESET(CORE_RESET), .CORE_HOLD(CORE_HOLD), .MEM_REQ(MEM_REQ),
    .MEM_CMD(MEM_CMD), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA)
);

// ### sim/fpmc_core_model.sv
// Behavioural core and program memory facing the panel.
// Shares the panel clock; odd addresses answer slowly.
`timescale 1ns/10ps
module fpmc_core_model (
    // Clock
    input  wire logic                    clk,
    // Panel control and memory port
    input  wire logic                    core_reset,
    input  wire logic                    core_hold,
    input  wire logic                    mem_req,
    input  wire fpmc_pkg::fpmc_mem_cmd_t mem_cmd,
    output logic                         mem_ack,
    output logic [7:0]                   mem_rdata,
    // Core outputs
    output logic                         core_flag,
    output logic                         core_out_stb,
    output logic [7:0]                   core_out_data
);
    import fpmc_pkg::*;
    logic [7:0] mem [0:15];  // Small program store
    logic [1:0] wait_reg;    // Answer delay count
    logic [7:0] last_reg;    // Byte read for the panel
    logic [7:0] out_reg;     // Byte sent to the leds
    logic [3:0] pc_reg;      // Fetch pointer
    logic [1:0] step_reg;    // Instruction phase
    initial begin
        mem_ack = 1'b0;
        core_out_stb = 1'b0;
        wait_reg = 2'h0;
        for (int i = 0; i < 16; i++) mem[i] = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////
    // One answer per request; only a write alters memory
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        if (mem_req && !mem_ack) begin
            if (wait_reg == (mem_cmd.addr[0] ? 2'h2 : 2'h0)) begin
                mem_ack <= 1'b1;
                wait_reg <= 2'h0;
                last_reg <= mem[mem_cmd.addr[3:0]];
                if (mem_cmd.we) mem[mem_cmd.addr[3:0]] <= mem_cmd.wdata;
            end else begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
    // Released lines show the inverse, never a stale copy
    assign mem_rdata = mem_ack ? last_reg : ~last_reg;
    assign core_out_data = core_out_stb ? out_reg : ~out_reg;
    ////////////////////////////////////////////////////////////////////
    // Reset clears fetch pointer and flag
    always @(posedge clk) begin
        core_out_stb <= 1'b0;
        if (core_reset) begin
            pc_reg <= 4'h0;
            step_reg <= 2'h0;
            core_flag <= 1'b0;
        end else if (!core_hold) begin // Held keeps all state
            step_reg <= step_reg + 2'h1;
            core_flag <= ~core_flag;
            if (step_reg == 2'h3) begin // Output the fetched byte
                core_out_stb <= 1'b1;
                out_reg <= mem[pc_reg];
                pc_reg <= pc_reg + 4'h1;
            end
        end
    end
endmodule

// ### sim/fpmc_front_panel_tb_top.sv
// Testbench for the front-panel block: drives switches and APB,
// with the behavioural core and memory on the far side.
`timescale 1ns/10ps
module fpmc_front_panel_tb_top;
    import fpmc_pkg::*;
    localparam int DEB  = 8;        // Short debounce for simulation
    localparam int HOLD = DEB + 12; // Press or release time in clocks
    logic          clk_sys, rst_b, btn, rw_sw, rst_sw, load_sw;
    logic [7:0]    data_sw, leds, out_data, mem_rdata, paddr;
    logic          flag_led, core_flag, out_stb, core_reset, core_hold;
    logic          mem_req, mem_ack, psel, penable, pwrite, pready;
    logic          pslverr, err;
    logic [31:0]   pwdata, prdata, rd;
    fpmc_mem_cmd_t mem_cmd;
    int            n_errors, total_checks;
    logic [7:0]    tbl [0:2] = '{8'h7B, 8'h7A, 8'h30}; // Program bytes
    fpmc_front_panel #(.DEBOUNCE_CYC(DEB)) dut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .DATA_SWITCHES(data_sw),
        .INPUT_PUSHBUTTON(btn), .READ_WRITE_SELECT_SWITCH(rw_sw),
        .RESET_MODE_SWITCH(rst_sw), .LOAD_MODE_SWITCH(load_sw),
        .DATA_LEDS(leds), .FLAG_LED(flag_led), .CORE_FLAG(core_flag),
        .CORE_OUT_STB(out_stb), .CORE_OUT_DATA(out_data),
        .CORE_RESET(core_reset), .CORE_HOLD(core_hold),
        .MEM_REQ(mem_req), .MEM_CMD(mem_cmd), .MEM_ACK(mem_ack),
        .MEM_RDATA(mem_rdata), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    fpmc_core_model u_core (
        .clk(clk_sys), .core_reset(core_reset), .core_hold(core_hold),
        .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .core_flag(core_flag),
        .core_out_stb(out_stb), .core_out_data(out_data));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    // One APB transfer; request held until PREADY is sampled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) finish_test(1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Mode switches change, then synchroniser lag passes
    task automatic set_mode(input logic r, input logic l);
        rst_sw <= r;
        load_sw <= l;
        repeat (12) @(posedge clk_sys);
    endtask
    // Clean press: long enough to outlast the debounce
    task automatic press;
        btn <= 1'b1;
        repeat (HOLD) @(posedge clk_sys);
        btn <= 1'b0;
        repeat (HOLD) @(posedge clk_sys);
    endtask
    task automatic read_pc(input int exp);
        apb(1'b0, OFS_PC, 32'h0);
        chk("pc", 32'(exp), rd);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        read_pc(0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("mode", 32'(MODE_CLEAR), 32'(rd[1:0]));
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        $display("test regs done");
    endtask
    task automatic t_load(input logic wr);
        set_mode(1'b0, 1'b1);
        rw_sw <= wr;
        set_mode(1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            data_sw <= wr ? tbl[i] : ~tbl[i];
            if (!wr && i == 2) begin // Software press
                apb(1'b1, OFS_CMD, 32'h1);
                repeat (12) @(posedge clk_sys);
            end else begin
                press();
            end
            chk("leds", 32'(tbl[i]), 32'(leds));
            chk("mem", 32'(tbl[i]), 32'(u_core.mem[i]));
            apb(1'b0, OFS_LEDS, 32'h0);
            chk("led reg", 32'(tbl[i]), rd);
            read_pc(i + 1);
        end
        $display("test load done");
    endtask
    // Press outside load is dropped; bouncing gives one step
    task automatic t_bounce;
        set_mode(1'b1, 1'b0);
        press();
        read_pc(3);
        apb(1'b1, OFS_PC, 32'h5); // Preset, allowed outside run
        set_mode(1'b0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            btn <= 1'b1;
            repeat (2) @(posedge clk_sys);
            btn <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        press();
        read_pc(6);
        $display("test bounce done");
    endtask
    task automatic t_run_wait;
        int  n;
        logic f;
        n = 0;
        set_mode(1'b0, 1'b1);
        read_pc(0);
        rst_sw <= 1'b1;
        load_sw <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (out_stb !== 1'b1 && n < 64);
        if (out_stb !== 1'b1) finish_test(1);
        #1;
        chk("run leds", 32'h7B, 32'(leds));
        @(posedge clk_sys);
        set_mode(1'b1, 1'b0);
        f = flag_led;
        repeat (20) @(posedge clk_sys);
        chk("frozen flag", 32'(f), 32'(flag_led));
        chk("hold", 32'h1, 32'(core_hold));
        set_mode(1'b1, 1'b1);
        chk("resume", 32'h0, 32'(core_hold));
        $display("test run wait done");
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test(input int hung);
        n_errors += hung;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Start in clear mode, reset held five cycles
    initial begin
        {rst_b, btn, rw_sw, rst_sw, psel, penable, pwrite} = 7'h00;
        load_sw = 1'b1;
        data_sw = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_errors = 0;
        total_checks = 0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (12) @(posedge clk_sys);
        t_regs();
        t_load(1'b1);
        t_load(1'b0);
        t_bounce();
        t_run_wait();
        finish_test(0);
    end
endmodule
